// ### inc/psbr_defs.svh
// Purpose: Constants for the partition secondary bus reset sequencer.
// Assumes: Core clock mclk at 40 MHz.
// Notes: Counts are in core clock cycles.
`ifndef PSBR_DEFS_SVH
`define PSBR_DEFS_SVH
`define PSBR_NPORTS 4
`define PSBR_HOTRST_NS 2000
`define PSBR_CLK_NS 25
`define PSBR_HOTRST_CYC ((`PSBR_HOTRST_NS + `PSBR_CLK_NS - 1) / `PSBR_CLK_NS)
`define PSBR_FLUSH_CYC 8
`define PSBR_CNT_W 8
`endif

// ### inc/psbr_pkg.sv
// Purpose: Types for the partition secondary bus reset sequencer.
// Assumes: Nothing beyond the defs header.
// Notes: Gray codes from idle through train; train back to idle flips all three bits.
package psbr_pkg;
  typedef enum logic [2:0] {
    PSBR_IDLE = 3'h0,
    PSBR_PROP = 3'h1,
    PSBR_CLEAR = 3'h3,
    PSBR_FLUSH = 3'h2,
    PSBR_HOLD = 3'h6,
    PSBR_TRAIN = 3'h7
  } psbr_state_e;
endpackage : psbr_pkg

// ### inc/psbr_port_if.sv
// Purpose: Per-port control bundle between sequencer and port fan-out.
// Assumes: One bit per downstream port, except the shared propagate and hold commands.
// Notes: Sequencer drives commands, fan-out returns the per-port hot reset, detect and reset outputs.
interface psbr_port_if #(parameter int N = 4);
  logic [N-1:0] linkUp;
  logic [N-1:0] linkDisabled;
  logic propagate;
  logic hold;
  logic [N-1:0] sendHotReset;
  logic [N-1:0] toDetect;
  logic [N-1:0] portReset;
  modport seq (input linkUp, input linkDisabled, output propagate,
    output hold);
  modport fan (input linkUp, input linkDisabled, input propagate,
    input hold, output sendHotReset, output toDetect, output portReset);
endinterface : psbr_port_if

// ### core/psbr_port_fan.sv
// Purpose: Turns sequencer commands into per-port link actions.
// Assumes: Link status is on the core clock.
// Notes: Outputs are registered.
module psbr_port_fan #(
  parameter int N = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  psbr_port_if.fan pif
);
  logic [N-1:0] hot_q, hot_d, det_q, det_d, rst_q, rst_d;

  always_comb begin
    hot_d = '0;
    det_d = '0;
    rst_d = pif.hold ? {N{1'b1}} : '0;
    if (pif.propagate) begin
      hot_d = pif.linkUp & ~pif.linkDisabled;
      det_d = pif.linkDisabled;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hot_q <= '0;
      det_q <= '0;
      rst_q <= '0;
    end else begin
      hot_q <= hot_d;
      det_q <= det_d;
      rst_q <= rst_d;
    end
  end

  assign pif.sendHotReset = hot_q;
  assign pif.toDetect = det_q;
  assign pif.portReset = rst_q;
endmodule : psbr_port_fan

// ### core/psbr_seq.sv
// Purpose: Upstream secondary bus reset sequencer for one partition.
// Assumes: Config block gives the bridge control secondary reset bit level.
// Notes: Only bridge (Type 1) functions present the secondary reset bit.
`include "psbr_defs.svh"
module psbr_seq #(
  parameter int N = `PSBR_NPORTS,
  parameter int HOTRST_CYC = `PSBR_HOTRST_CYC,
  parameter int FLUSH_CYC = `PSBR_FLUSH_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic isBridgeFunc,
  input wire logic secondaryResetBit,
  input wire logic linkDownHotResetDisable,
  input wire logic upDataLinkDown,
  input wire logic upHotResetTs1,
  input wire logic [N-1:0] linkUp,
  input wire logic [N-1:0] linkDisabled,
  input wire logic upLinkUpIn,
  output logic [N-1:0] sendHotReset,
  output logic [N-1:0] toDetect,
  output logic [N-1:0] portReset,
  output logic clearNonSticky,
  output logic flushQueues,
  output logic coreReset,
  output logic startTraining,
  output logic secondaryUr,
  output logic upLinkKeep,
  output logic partHotReset,
  output logic aspmIndependent,
  output psbr_pkg::psbr_state_e seqState
);
  import psbr_pkg::*;

  // Sequencer state
  psbr_state_e state_q;
  psbr_state_e state_d;
  logic [`PSBR_CNT_W-1:0] cnt_q;
  logic [`PSBR_CNT_W-1:0] cnt_d;
  logic bit_q;
  logic bit_d;

  // Output registers
  logic clr_q;
  logic clr_d;
  logic fl_q;
  logic fl_d;
  logic cr_q;
  logic cr_d;
  logic tr_q;
  logic tr_d;
  logic ur_q;
  logic ur_d;
  logic ph_q;
  logic ph_d;
  logic aspm_q;
  logic aspm_d;
  logic srBit;
  logic startPulse;
  logic linkDownTrig;

  localparam int CNT_MAX = (1 << `PSBR_CNT_W) - 1;

  // Port fan-out
  psbr_port_if #(.N(N)) pif ();

  psbr_port_fan #(.N(N)) u_fan (
    .mclk(mclk),
    .resetn(resetn),
    .pif(pif.fan)
  );

  assign srBit = secondaryResetBit & isBridgeFunc;
  // Edge on the bit; a level held high never restarts
  assign startPulse = srBit & ~bit_q;
  // Link-down trigger only; training-set trigger is never masked
  assign linkDownTrig = upDataLinkDown & ~linkDownHotResetDisable;

  // Load N-1 so a state lasts N cycles; an oversized
  // count saturates instead of wrapping short
  function automatic logic [`PSBR_CNT_W-1:0] cntOf(input int c);
    int load;
    load = (c > 0) ? c - 1 : 0;
    if (load > CNT_MAX) begin
      load = CNT_MAX;
    end
    cntOf = `PSBR_CNT_W'(load);
  endfunction : cntOf

  // Ports stay in reset from start until release
  function automatic logic holdsPorts(input psbr_state_e s);
    holdsPorts = (s != PSBR_IDLE) && (s != PSBR_TRAIN);
  endfunction : holdsPorts

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = srBit;
    clr_d = 1'b0;
    fl_d = 1'b0;
    cr_d = 1'b0;
    tr_d = 1'b0;
    ur_d = ur_q;
    ph_d = upHotResetTs1 | linkDownTrig;
    // Low-power states per port while upstream is gone and link-down hot reset is disabled
    aspm_d = upDataLinkDown & linkDownHotResetDisable;
    case (state_q)
      PSBR_IDLE: begin
        ur_d = 1'b0;
        if (startPulse) begin
          state_d = PSBR_PROP;
          cnt_d = cntOf(HOTRST_CYC);
          // Secondary-side requests refused until release
          ur_d = 1'b1;
        end
      end
      PSBR_PROP: begin
        // Hot reset goes out while counting down
        if (cnt_q == '0) begin
          state_d = PSBR_CLEAR;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      PSBR_CLEAR: begin
        // Sticky fields are kept by the register file
        clr_d = 1'b1;
        state_d = PSBR_FLUSH;
        cnt_d = cntOf(FLUSH_CYC);
      end
      PSBR_FLUSH: begin
        // Queues and core logic reset together
        fl_d = 1'b1;
        cr_d = 1'b1;
        if (cnt_q == '0) begin
          state_d = PSBR_HOLD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      PSBR_HOLD: begin
        // An early clear of the bit is only seen here
        if (!srBit) begin
          state_d = PSBR_TRAIN;
        end
      end
      PSBR_TRAIN: begin
        // Ports leave reset and start link training
        tr_d = 1'b1;
        ur_d = 1'b0;
        state_d = PSBR_IDLE;
      end
      default: begin
        // Unused codes fall back to idle
        state_d = PSBR_IDLE;
      end
    endcase
  end

  // Register stage only; all decisions are above
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= PSBR_IDLE;
      cnt_q <= '0;
      bit_q <= 1'b0;
      clr_q <= 1'b0;
      fl_q <= 1'b0;
      cr_q <= 1'b0;
      tr_q <= 1'b0;
      ur_q <= 1'b0;
      ph_q <= 1'b0;
      aspm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      clr_q <= clr_d;
      fl_q <= fl_d;
      cr_q <= cr_d;
      tr_q <= tr_d;
      ur_q <= ur_d;
      ph_q <= ph_d;
      aspm_q <= aspm_d;
    end
  end

  assign pif.linkUp = linkUp;
  assign pif.linkDisabled = linkDisabled;
  // Fan-out registers these, so ports lag the state by one
  assign pif.propagate = (state_q == PSBR_PROP);
  assign pif.hold = holdsPorts(state_q);

  assign sendHotReset = pif.sendHotReset;
  assign toDetect = pif.toDetect;
  assign portReset = pif.portReset;
  // Status outputs straight from their registers
  assign clearNonSticky = clr_q;
  assign flushQueues = fl_q;
  assign coreReset = cr_q;
  assign startTraining = tr_q;
  assign secondaryUr = ur_q;
  // Upstream link untouched by this sequence
  assign upLinkKeep = upLinkUpIn;
  assign partHotReset = ph_q;
  assign aspmIndependent = aspm_q;
  assign seqState = state_q;
endmodule : psbr_seq

// ### verification/psbr_seq_asserts.sv
// Purpose: Port checks for the reset sequencer.
// Assumes: N downstream ports, four by default.
// Notes: Bound to every sequencer.
module psbr_seq_asserts import psbr_pkg::*; #(
  parameter int N = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic secondaryResetBit,
  input wire logic isBridgeFunc,
  input wire logic linkDownHotResetDisable,
  input wire logic upDataLinkDown,
  input wire logic upHotResetTs1,
  input wire logic [N-1:0] linkUp,
  input wire logic [N-1:0] linkDisabled,
  input wire logic [N-1:0] sendHotReset,
  input wire logic [N-1:0] toDetect,
  input wire logic [N-1:0] portReset,
  input wire logic clearNonSticky,
  input wire logic flushQueues,
  input wire logic coreReset,
  input wire logic startTraining,
  input wire logic secondaryUr,
  input wire logic partHotReset,
  input wire logic aspmIndependent,
  input wire psbr_state_e seqState
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  start_a: assert property ($rose(secondaryResetBit && isBridgeFunc) &&
    seqState == PSBR_IDLE |=> seqState == PSBR_PROP) else $error("no start");
  hot_a: assert property ($past(seqState) == PSBR_PROP |->
    sendHotReset == ($past(linkUp) & ~$past(linkDisabled)))
    else $error("hot reset");
  detect_a: assert property ($past(seqState) == PSBR_PROP |->
    toDetect == $past(linkDisabled)) else $error("detect");
  hold_a: assert property (seqState == PSBR_HOLD && secondaryResetBit &&
    isBridgeFunc |=> seqState == PSBR_HOLD && portReset == {N{1'b1}})
    else $error("hold");
  order_a: assert property (seqState == PSBR_PROP ##1
    seqState != PSBR_PROP |-> seqState == PSBR_CLEAR ##1
    seqState == PSBR_FLUSH && clearNonSticky) else $error("order");
  flush_a: assert property (seqState == PSBR_FLUSH |=>
    flushQueues && coreReset) else $error("flush");
  release_a: assert property (seqState == PSBR_HOLD &&
    !secondaryResetBit |=> seqState == PSBR_TRAIN ##1 startTraining &&
    !secondaryUr) else $error("release");
  ur_a: assert property (seqState == PSBR_HOLD |-> secondaryUr)
    else $error("ur");
  ts1_a: assert property (upHotResetTs1 |=> partHotReset)
    else $error("ts1");
  aspm_a: assert property (upDataLinkDown &&
    linkDownHotResetDisable && !upHotResetTs1 |=>
    aspmIndependent && !partHotReset) else $error("aspm");
  cover property (seqState == PSBR_HOLD);
  cover property (startTraining);
  cover property (aspmIndependent);
endmodule : psbr_seq_asserts
bind psbr_seq psbr_seq_asserts #(.N(N)) psbr_seq_asserts_i(.*);

// ### verification/psbr_link_partner.sv
// Purpose: Link status of downstream partners and upstream link.
// Assumes: Ports 0 and 3 up, port 1 disabled, port 2 absent.
// Notes: Static status.
module psbr_link_partner (
  output logic [3:0] linkUp,
  output logic [3:0] linkDisabled,
  output logic upLinkUpIn
);
  timeunit 1ns;
  timeprecision 100ps;
  assign linkUp = 4'h9;
  assign linkDisabled = 4'h2;
  assign upLinkUpIn = 1'b1;
endmodule : psbr_link_partner

// ### verification/partition_secondary_bus_reset_test.sv
// Purpose: Directed tests of the reset sequencer.
// Assumes: Short counts through parameters.
// Notes: Inputs change on falling edges.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fail_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module partition_secondary_bus_reset_test import psbr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, resetn = 0, isBridgeFunc = 1, secondaryResetBit = 0;
  logic linkDownHotResetDisable = 0, upDataLinkDown = 0, upHotResetTs1 = 0;
  logic [3:0] linkUp, linkDisabled, sendHotReset, toDetect, portReset;
  logic upLinkUpIn, clearNonSticky, flushQueues, coreReset, startTraining;
  logic secondaryUr, upLinkKeep, partHotReset, aspmIndependent;
  psbr_state_e seqState;
  int fail_count = 0;
  int samples_checked = 0;
  always #12.5 mclk = ~mclk;
  psbr_link_partner psbr_link_partner_i(.*);
  psbr_seq #(.HOTRST_CYC(2), .FLUSH_CYC(1)) psbr_seq_i(.*);
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic summarize;
    $display("fail_count=%0d samples_checked=%0d", fail_count,
      samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic testBusReset;
    int k;
    logic sawClr;
    sawClr = 1'b0;
    secondaryResetBit = 1;
    tick(3);
    `CHK(sendHotReset, 4'h9)
    `CHK(toDetect, 4'h2)
    for (k = 0; k < 50 && seqState !== PSBR_HOLD; k++) begin
      sawClr |= clearNonSticky;
      tick(1);
    end
    `CHK(seqState, PSBR_HOLD)
    `CHK(sawClr, 1'b1)
    `CHK(flushQueues, 1'b1)
    `CHK(coreReset, 1'b1)
    `CHK(sendHotReset, 4'h0)
    tick(30);
    `CHK(portReset, 4'hf)
    `CHK(secondaryUr, 1'b1)
    `CHK(upLinkKeep, 1'b1)
    secondaryResetBit = 0;
    for (k = 0; k < 10 && startTraining !== 1'b1; k++) tick(1);
    `CHK(startTraining, 1'b1)
    `CHK(secondaryUr, 1'b0)
    `CHK(portReset, 4'h0)
    tick(1);
    `CHK(startTraining, 1'b0)
  endtask : testBusReset
  task automatic testNonBridge;
    isBridgeFunc = 0;
    secondaryResetBit = 1;
    tick(10);
    `CHK(seqState, PSBR_IDLE)
    secondaryResetBit = 0;
    isBridgeFunc = 1;
    tick(2);
  endtask : testNonBridge
  task automatic testLinkDown;
    linkDownHotResetDisable = 1;
    upDataLinkDown = 1;
    tick(3);
    `CHK(aspmIndependent, 1'b1)
    `CHK(partHotReset, 1'b0)
    upHotResetTs1 = 1;
    tick(3);
    `CHK(partHotReset, 1'b1)
    upHotResetTs1 = 0;
    linkDownHotResetDisable = 0;
    tick(3);
    `CHK(partHotReset, 1'b1)
    `CHK(aspmIndependent, 1'b0)
    upDataLinkDown = 0;
    tick(3);
  endtask : testLinkDown
  initial begin
    tick(5);
    resetn = 1;
    tick(2);
    testBusReset();
    testNonBridge();
    testLinkDown();
    testBusReset();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    summarize();
  end
endmodule : partition_secondary_bus_reset_test
